// file: design/mhp_pkg.sv
// Constants and types shared by the supply monitor host port
package mhp_pkg;
  // Clock and timing
  localparam int CLK_MHZ        = 250;
  localparam int FLASH_HALF_MS  = 250;
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * 1000 * CLK_MHZ;
  localparam int FLASH_CNT_W    = 26;

  // Sample record geometry
  localparam int BUF_NUM   = 4;
  localparam int SMP_W     = 10;
  localparam int PTR_W     = 6;
  localparam int RAM_AW    = 8;
  localparam int RAM_DEPTH = 256;
  localparam logic [5:0] BUF_LAST = 6'h31;
  localparam logic [5:0] POST_MAX = 6'h32;

  // Register indices, byte address is four times the index
  localparam logic [7:0] R_CH_CTRL  = 8'h00;
  localparam logic [7:0] R_STRAPS   = 8'h01;
  localparam logic [7:0] R_CH_STAT  = 8'h02;
  localparam logic [7:0] R_BUF_CTRL = 8'h03;
  localparam logic [7:0] R_POST_CNT = 8'h07;
  localparam logic [7:0] R_BUF_SEL  = 8'h08;
  localparam logic [7:0] R_BUF_IDX  = 8'h09;
  localparam logic [7:0] R_BUF_LO   = 8'h0a;
  localparam logic [7:0] R_BUF_HI   = 8'h0b;
  localparam logic [7:0] R_BUF_STAT = 8'h0c;
  localparam logic [7:0] R_BUF_WPTR = 8'h0d;
  localparam logic [7:0] R_LED_SET  = 8'h0e;
  localparam logic [7:0] R_LED_FLSH = 8'h0f;
  localparam logic [7:0] R_LED_PULL = 8'h10;
  localparam logic [7:0] R_LED_PHS  = 8'h11;
  localparam logic [7:0] R_LED_IN   = 8'h12;
  localparam logic [7:0] R_IRQ_STAT = 8'h13;
  localparam logic [7:0] R_IRQ_CLR  = 8'h14;
  localparam logic [7:0] R_IRQ_EN   = 8'h15;

  // Field positions
  localparam int CTRL_RUN_BIT   = 0;
  localparam int CTRL_RES10_BIT = 1;
  localparam int IRQ_FRZ_LSB    = 0;
  localparam int IRQ_CHON_LSB   = 4;
  localparam int IRQ_W          = 6;

  // Reset values
  localparam logic [1:0] BUF_CTRL_RST = 2'h1;
  localparam logic [5:0] POST_RST     = 6'h00;
  localparam logic [3:0] LED_RST      = 4'h0;
  localparam logic [5:0] IRQ_EN_RST   = 6'h00;
  localparam logic [6:0] ADDR_RST     = 7'h35;

  // Bus address per strap pair, index is high strap * 3 + low strap
  localparam logic [3:0] ADDR_IDX_MAX = 4'h8;
  localparam logic [3:0] ADDR_IDX_DEF = 4'h4;
  localparam logic [7:0] ADDR_TBL [9] = '{8'h60, 8'h62, 8'h64, 8'h68, 8'h6a,
                                          8'h6c, 8'h70, 8'h72, 8'h74};

  // Power-up sequence
  typedef enum logic [1:0] {
    ST_OFF  = 2'b00,
    ST_LOAD = 2'b01,
    ST_RUN  = 2'b10
  } mhp_pwr_t;

  // Two-wire target sequence
  typedef enum logic [3:0] {
    I_IDLE = 4'h0,
    I_ADDR = 4'h1,
    I_AACK = 4'h2,
    I_CMD  = 4'h3,
    I_CACK = 4'h4,
    I_WDAT = 4'h5,
    I_WACK = 4'h6,
    I_RDAT = 4'h7,
    I_RACK = 4'h8
  } mhp_i2c_t;
endpackage

// file: design/mhp_ram.sv
// Sample record memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module mhp_ram (
  // Clock
  input  wire logic                         clk_i,
  // Write port
  input  wire logic                         we_i,
  input  wire logic [mhp_pkg::RAM_AW-1:0]   waddr_i,
  input  wire logic [mhp_pkg::SMP_W-1:0]    wdata_i,
  // Read port
  input  wire logic [mhp_pkg::RAM_AW-1:0]   raddr_i,
  output logic      [mhp_pkg::SMP_W-1:0]    rdata_o
);
  logic [mhp_pkg::SMP_W-1:0] mem_q [mhp_pkg::RAM_DEPTH];

  // No reset on the array, contents are only meaningful once written
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule
`default_nettype wire

// file: design/mhp_top.sv
// Supply monitor host port: two-wire target, registers, sample record
// Function
// - Each channel keeps voltage and current buffers of the 50 newest samples.
// - Each buffer stores samples at a selectable 8-bit or 10-bit width.
// - After a shutdown while running, record the post count, then freeze.
// - A stopped buffer takes no new samples and keeps its contents.
// - The post-shutdown sample count accepts values 0 through 50.
// - Converter results for current and voltage feed the buffer logic.
// - Only single-byte register writes and single-byte register reads exist.
// - Two address straps select the bus address, default 0110101.
// - Strap pairs map to write addresses 0x60 through 0x74, reads one higher.
// - Both channels stay off until supply-good is seen after reset.
// - Initial settings load into registers before any channel may turn on.
// - Startup straps set range, protection, polarity, enable, fault mode, address.
// - A channel turns on and is monitored only while its input qualifies.
// - Four open-drain indicator pins with set, flash, pull-up and phase.
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module mhp_top #(
  parameter int FLASH_HALF_CYC = mhp_pkg::FLASH_HALF_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Two-wire target pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // Supervision and strap pins
  input  wire logic        supply_good_i,
  input  wire logic [1:0]  on_qual_i,
  input  wire logic [1:0]  addr_strap_low_i,
  input  wire logic [1:0]  addr_strap_high_i,
  input  wire logic [1:0]  strap_range_i,
  input  wire logic        strap_prot_i,
  input  wire logic        strap_pol_i,
  input  wire logic        strap_hwen_i,
  input  wire logic        strap_retry_i,
  // Converter results and shutdown events
  input  wire logic        adc_valid_i,
  input  wire logic [1:0]  adc_sel_i,
  input  wire logic [9:0]  adc_data_i,
  input  wire logic [1:0]  shutdown_i,
  // Channel, indicator and interrupt outputs
  output logic      [1:0]  ch_on_o,
  output logic      [3:0]  led_o,
  output logic      [3:0]  led_oe_o,
  output logic      [3:0]  led_pu_o,
  input  wire logic [3:0]  led_in_i,
  output logic             irq_o
);
  localparam int PIN_W = 19;

  logic [PIN_W-1:0] meta_q, sync_q;
  logic             sup_s, scl_s, sda_s, scl_d1_q, sda_d1_q;
  logic [1:0]       onq_s, alo_s, ahi_s, rng_s;
  logic [3:0]       ledin_s;
  logic [3:0]       sprt_s;
  mhp_pkg::mhp_pwr_t pwr_q;
  mhp_pkg::mhp_i2c_t ist_q;
  logic [7:0]       ish_q, ptr_q, itx_q;
  logic [3:0]       icnt_q;
  logic             irw_q, sda_oe_q, i2c_wr_q, od_lo_q, ack_q, irq_q;
  logic [31:0]      dat_q;
  logic [6:0]       addr_q;
  logic [5:0]       strap_q;
  logic [1:0]       ch_en_q, ch_on_q, ch_on_d;
  logic [1:0]       bctl_q [mhp_pkg::BUF_NUM];
  logic [5:0]       wptr_q [mhp_pkg::BUF_NUM];
  logic [5:0]       post_q [mhp_pkg::BUF_NUM];
  logic [3:0]       trig_q, frz_q, frz_ev, wr_b, arm_b, shut_b, bctl_we;
  logic [5:0]       post_cnt_q;
  logic [1:0]       bsel_q;
  logic [5:0]       bidx_q;
  logic [3:0]       lset_q, lflsh_q, lpull_q, lphs_q, led_oe_q, led_on;
  logic [mhp_pkg::FLASH_CNT_W-1:0] fcnt_q;
  logic             blink_q;
  logic [5:0]       ist_stat_q, irq_en_q, irq_set, irq_clr;
  logic [9:0]       rdata, wdata;

  // Every supervision, two-wire, strap and indicator pin passes two flops before any logic looks at it
  always_ff @(posedge clk_i) begin
    meta_q <= {supply_good_i, on_qual_i, scl_i, sda_i, led_in_i, addr_strap_high_i,
               addr_strap_low_i, strap_range_i, strap_retry_i, strap_hwen_i,
               strap_pol_i, strap_prot_i};
    sync_q <= meta_q;
  end
  assign {sup_s, onq_s, scl_s, sda_s, ledin_s, ahi_s, alo_s, rng_s, sprt_s} = sync_q;

  // Bus edge detection on the synchronised pins
  always_ff @(posedge clk_i) begin
    scl_d1_q <= rst_i ? 1'b1 : scl_s;
    sda_d1_q <= rst_i ? 1'b1 : sda_s;
  end
  wire scl_rise = scl_s & ~scl_d1_q;
  wire scl_fall = ~scl_s & scl_d1_q;
  wire i_start  = scl_s & scl_d1_q & sda_d1_q & ~sda_s;
  wire i_stop   = scl_s & scl_d1_q & ~sda_d1_q & sda_s;
  wire rx_st    = (ist_q == mhp_pkg::I_ADDR) | (ist_q == mhp_pkg::I_CMD) |
                  (ist_q == mhp_pkg::I_WDAT);

  wire [3:0] aidx_raw = {2'b00, ahi_s} * 4'h3 + {2'b00, alo_s};
  wire [3:0] aidx     = (aidx_raw > mhp_pkg::ADDR_IDX_MAX) ? mhp_pkg::ADDR_IDX_DEF : aidx_raw;
  wire [7:0] addr_wr  = mhp_pkg::ADDR_TBL[aidx];

  // Shared register write port, the two-wire side wins a collision
  wire       wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire       wb_go  = wb_req & ~(wb_we_i & i2c_wr_q);
  wire       wb_wr  = wb_go & wb_we_i & wb_sel_i[0];
  wire       wr_en  = i2c_wr_q | wb_wr;
  wire [7:0] wr_idx = i2c_wr_q ? ptr_q : wb_adr_i[9:2];
  wire [7:0] wr_dat = i2c_wr_q ? ish_q : wb_dat_i[7:0];
  wire       we_post = wr_en & (wr_idx == mhp_pkg::R_POST_CNT);

  // Register read selection, unmapped indices read as zero
  function automatic logic [7:0] rd_fn(input logic [7:0] i);
    unique case (i)
      mhp_pkg::R_CH_CTRL:  rd_fn = {6'h00, ch_en_q};
      mhp_pkg::R_STRAPS:   rd_fn = {2'h0, strap_q};
      mhp_pkg::R_CH_STAT:  rd_fn = {3'h0, pwr_q == mhp_pkg::ST_RUN, onq_s, ch_on_q};
      mhp_pkg::R_BUF_CTRL: rd_fn = {6'h00, bctl_q[0]};
      mhp_pkg::R_BUF_CTRL + 8'h01: rd_fn = {6'h00, bctl_q[1]};
      mhp_pkg::R_BUF_CTRL + 8'h02: rd_fn = {6'h00, bctl_q[2]};
      mhp_pkg::R_BUF_CTRL + 8'h03: rd_fn = {6'h00, bctl_q[3]};
      mhp_pkg::R_POST_CNT: rd_fn = {2'h0, post_cnt_q};
      mhp_pkg::R_BUF_SEL:  rd_fn = {6'h00, bsel_q};
      mhp_pkg::R_BUF_IDX:  rd_fn = {2'h0, bidx_q};
      mhp_pkg::R_BUF_LO:   rd_fn = rdata[7:0];
      mhp_pkg::R_BUF_HI:   rd_fn = {6'h00, rdata[9:8]};
      mhp_pkg::R_BUF_STAT: rd_fn = {trig_q, frz_q};
      mhp_pkg::R_BUF_WPTR: rd_fn = {2'h0, wptr_q[bsel_q]};
      mhp_pkg::R_LED_SET:  rd_fn = {4'h0, lset_q};
      mhp_pkg::R_LED_FLSH: rd_fn = {4'h0, lflsh_q};
      mhp_pkg::R_LED_PULL: rd_fn = {4'h0, lpull_q};
      mhp_pkg::R_LED_PHS:  rd_fn = {4'h0, lphs_q};
      mhp_pkg::R_LED_IN:   rd_fn = {4'h0, ledin_s};
      mhp_pkg::R_IRQ_STAT: rd_fn = {2'h0, ist_stat_q};
      mhp_pkg::R_IRQ_EN:   rd_fn = {2'h0, irq_en_q};
      default:             rd_fn = 8'h00;
    endcase
  endfunction
  wire [7:0] i2c_rd = rd_fn(ptr_q);

  // Wishbone answer one edge after the request is seen
  always_ff @(posedge clk_i) begin
    ack_q <= ~rst_i & wb_go;
    dat_q <= rst_i ? 32'h0 : (wb_go ? {24'h0, rd_fn(wb_adr_i[9:2])} : dat_q);
  end

  // Two-wire target, bits follow SCL edges, start and stop follow SDA edges while SCL is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_q    <= mhp_pkg::I_IDLE;
      ish_q    <= 8'h00;
      icnt_q   <= 4'h0;
      irw_q    <= 1'b0;
      ptr_q    <= 8'h00;
      itx_q    <= 8'h00;
      sda_oe_q <= 1'b0;
      i2c_wr_q <= 1'b0;
    end else begin
      i2c_wr_q <= 1'b0;
      if (i_stop) begin
        ist_q    <= mhp_pkg::I_IDLE;
        sda_oe_q <= 1'b0;
      end else if (i_start) begin
        ist_q    <= mhp_pkg::I_ADDR;
        icnt_q   <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (scl_rise) begin
        if (rx_st) begin
          ish_q <= {ish_q[6:0], sda_s};
        end
        icnt_q <= icnt_q + 4'h1;
      end else if (scl_fall) begin
        unique case (ist_q)
          mhp_pkg::I_IDLE: ;
          mhp_pkg::I_ADDR: if (icnt_q == 4'h8) begin
            if (ish_q[7:1] == addr_q && pwr_q == mhp_pkg::ST_RUN) begin
              ist_q    <= mhp_pkg::I_AACK;
              irw_q    <= ish_q[0];
              sda_oe_q <= 1'b1;
            end else begin
              ist_q <= mhp_pkg::I_IDLE;
            end
          end
          mhp_pkg::I_AACK: begin
            icnt_q <= 4'h0;
            if (irw_q) begin
              ist_q    <= mhp_pkg::I_RDAT;
              itx_q    <= {i2c_rd[6:0], 1'b0};
              sda_oe_q <= ~i2c_rd[7];
            end else begin
              ist_q    <= mhp_pkg::I_CMD;
              sda_oe_q <= 1'b0;
            end
          end
          mhp_pkg::I_CMD: if (icnt_q == 4'h8) begin
            ptr_q    <= ish_q;
            ist_q    <= mhp_pkg::I_CACK;
            sda_oe_q <= 1'b1;
          end
          mhp_pkg::I_CACK: begin
            ist_q    <= mhp_pkg::I_WDAT;
            icnt_q   <= 4'h0;
            sda_oe_q <= 1'b0;
          end
          mhp_pkg::I_WDAT: if (icnt_q == 4'h8) begin
            i2c_wr_q <= 1'b1;
            ist_q    <= mhp_pkg::I_WACK;
            sda_oe_q <= 1'b1;
          end
          // single byte only, a second data byte is not acknowledged
          mhp_pkg::I_WACK: begin
            ist_q    <= mhp_pkg::I_IDLE;
            sda_oe_q <= 1'b0;
          end
          mhp_pkg::I_RDAT: if (icnt_q == 4'h8) begin
            ist_q    <= mhp_pkg::I_RACK;
            sda_oe_q <= 1'b0;
          end else begin
            itx_q    <= {itx_q[6:0], 1'b0};
            sda_oe_q <= ~itx_q[7];
          end
          mhp_pkg::I_RACK: ist_q <= mhp_pkg::I_IDLE;
          default:         ist_q <= mhp_pkg::I_IDLE;
        endcase
      end
    end
  end

  // power-up sequence holds channels off until supply good
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_q <= mhp_pkg::ST_OFF;
    end else begin
      unique case (pwr_q)
        mhp_pkg::ST_OFF:  pwr_q <= sup_s ? mhp_pkg::ST_LOAD : mhp_pkg::ST_OFF;
        mhp_pkg::ST_LOAD: pwr_q <= mhp_pkg::ST_RUN;
        mhp_pkg::ST_RUN:  pwr_q <= sup_s ? mhp_pkg::ST_RUN : mhp_pkg::ST_OFF;
        default:          pwr_q <= mhp_pkg::ST_OFF;
      endcase
    end
  end

  // settings load in the state before channels may run
  // straps latched in each load step; later pin changes wait for the next load step
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strap_q <= 6'h00;
      addr_q  <= mhp_pkg::ADDR_RST;
      ch_en_q <= 2'b00;
    end else if (pwr_q == mhp_pkg::ST_LOAD) begin
      strap_q <= {sprt_s, rng_s};
      addr_q  <= addr_wr[7:1];
      ch_en_q <= {2{sprt_s[2]}};
    end else if (wr_en && wr_idx == mhp_pkg::R_CH_CTRL) begin
      ch_en_q <= wr_dat[1:0];
    end
  end

  // channel on only while its input qualifies
  assign ch_on_d = (pwr_q == mhp_pkg::ST_RUN) ? (onq_s & ch_en_q) : 2'b00;
  always_ff @(posedge clk_i) begin
    ch_on_q <= rst_i ? 2'b00 : ch_on_d;
  end

  // post count clamped to the record length
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      post_cnt_q <= mhp_pkg::POST_RST;
      bsel_q     <= 2'b00;
      bidx_q     <= 6'h00;
    end else if (wr_en) begin
      if (we_post) begin
        post_cnt_q <= (wr_dat > {2'h0, mhp_pkg::POST_MAX}) ? mhp_pkg::POST_MAX : wr_dat[5:0];
      end
      if (wr_idx == mhp_pkg::R_BUF_SEL) bsel_q <= wr_dat[1:0];
      if (wr_idx == mhp_pkg::R_BUF_IDX) bidx_q <= wr_dat[5:0];
    end
  end

  // Per-buffer record control; buffer bit 1 is the channel, bit 0 picks current
  for (genvar b = 0; b < mhp_pkg::BUF_NUM; b++) begin : g_buf
    assign bctl_we[b] = wr_en & (wr_idx == mhp_pkg::R_BUF_CTRL + 8'(b));
    assign arm_b[b]   = bctl_q[b][mhp_pkg::CTRL_RUN_BIT] & ~frz_q[b] & ~trig_q[b];
    assign shut_b[b]  = shutdown_i[b/2] & arm_b[b];
    // stopped or frozen buffers take no samples
    assign wr_b[b]    = adc_valid_i & (adc_sel_i == 2'(b)) & ch_on_q[b/2] &
                        bctl_q[b][mhp_pkg::CTRL_RUN_BIT] & ~frz_q[b];
    // freeze after the programmed post-event samples
    assign frz_ev[b]  = (wr_b[b] & trig_q[b] & post_q[b] == 6'h01) |
                        (shut_b[b] & post_cnt_q == 6'h00);
    // Rewriting control re-arms a frozen record
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        bctl_q[b] <= mhp_pkg::BUF_CTRL_RST;
        wptr_q[b] <= 6'h00;
        post_q[b] <= 6'h00;
        trig_q[b] <= 1'b0;
        frz_q[b]  <= 1'b0;
      end else begin
        // Control write clears the flags; an event in that cycle still lands
        if (bctl_we[b]) begin
          bctl_q[b] <= wr_dat[1:0];
          trig_q[b] <= 1'b0;
          frz_q[b]  <= 1'b0;
        end
        // wrap after the fiftieth entry, oldest overwritten
        if (wr_b[b]) begin
          wptr_q[b] <= (wptr_q[b] == mhp_pkg::BUF_LAST) ? 6'h00 : wptr_q[b] + 6'h01;
          if (trig_q[b]) post_q[b] <= post_q[b] - 6'h01;
        end
        if (shut_b[b]) begin
          trig_q[b] <= 1'b1;
          post_q[b] <= post_cnt_q;
        end
        if (frz_ev[b]) frz_q[b] <= 1'b1;
      end
    end
  end

  // 8-bit mode keeps the top eight bits, zero extended
  assign wdata = bctl_q[adc_sel_i][mhp_pkg::CTRL_RES10_BIT] ? adc_data_i :
                 {2'b00, adc_data_i[9:2]};

  mhp_ram u_ram (
    .clk_i   (clk_i),
    .we_i    (|wr_b),
    .waddr_i ({adc_sel_i, wptr_q[adc_sel_i]}),
    .wdata_i (wdata),
    .raddr_i ({bsel_q, bidx_q}),
    .rdata_o (rdata)
  );

  // indicator controls; blink phase flips per pin on request
  assign led_on = lset_q & (~lflsh_q | ({4{blink_q}} ^ lphs_q));
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lset_q   <= mhp_pkg::LED_RST;
      lflsh_q  <= mhp_pkg::LED_RST;
      lpull_q  <= mhp_pkg::LED_RST;
      lphs_q   <= mhp_pkg::LED_RST;
      led_oe_q <= 4'h0;
      od_lo_q  <= 1'b0;
    end else begin
      if (wr_en && wr_idx == mhp_pkg::R_LED_SET)  lset_q  <= wr_dat[3:0];
      if (wr_en && wr_idx == mhp_pkg::R_LED_FLSH) lflsh_q <= wr_dat[3:0];
      if (wr_en && wr_idx == mhp_pkg::R_LED_PULL) lpull_q <= wr_dat[3:0];
      if (wr_en && wr_idx == mhp_pkg::R_LED_PHS)  lphs_q  <= wr_dat[3:0];
      led_oe_q <= led_on;
    end
  end

  // Blink timebase; long period is a parameter so simulation can shorten it
  always_ff @(posedge clk_i) begin
    if (rst_i || fcnt_q == mhp_pkg::FLASH_CNT_W'(FLASH_HALF_CYC - 1)) begin
      fcnt_q <= '0;
    end else begin
      fcnt_q <= fcnt_q + 1'b1;
    end
    if (rst_i) blink_q <= 1'b0;
    else if (fcnt_q == mhp_pkg::FLASH_CNT_W'(FLASH_HALF_CYC - 1)) blink_q <= ~blink_q;
  end

  // Sticky interrupt flags; a set in the clear cycle wins
  assign irq_set = {ch_on_d & ~ch_on_q, frz_ev};
  assign irq_clr = (wr_en && wr_idx == mhp_pkg::R_IRQ_CLR) ? wr_dat[5:0] : 6'h00;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ist_stat_q <= 6'h00;
      irq_en_q   <= mhp_pkg::IRQ_EN_RST;
      irq_q      <= 1'b0;
    end else begin
      ist_stat_q <= (ist_stat_q & ~irq_clr) | irq_set;
      if (wr_en && wr_idx == mhp_pkg::R_IRQ_EN) irq_en_q <= wr_dat[5:0];
      irq_q <= |(ist_stat_q & irq_en_q);
    end
  end

  // Outputs straight from flops
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign sda_oe_o = sda_oe_q;
  assign sda_o    = od_lo_q;
  assign led_o    = {4{od_lo_q}};
  assign led_oe_o = led_oe_q;
  assign led_pu_o = lpull_q;
  assign ch_on_o  = ch_on_q;
  assign irq_o    = irq_q;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_load;
    pwr_q == mhp_pkg::ST_LOAD;
  endsequence
  sequence s_run_off;
    ##1 pwr_q == mhp_pkg::ST_RUN && ch_on_q == 2'b00;
  endsequence

  wptr_range_a: assert property (wptr_q[0] <= mhp_pkg::BUF_LAST)
    else $error("record pointer past last entry");
  res8_store_a: assert property (
    (adc_valid_i && !bctl_q[adc_sel_i][1]) |-> wdata[9:8] == 2'b00)
    else $error("8-bit sample stored with high bits");
  post_freeze_a: assert property (frz_ev[0] |=> frz_q[0] && !wr_b[0])
    else $error("record did not freeze");
  stop_nowrite_a: assert property (!bctl_q[1][0] |-> !wr_b[1])
    else $error("stopped buffer written");
  post_clamp_a: assert property (post_cnt_q <= mhp_pkg::POST_MAX)
    else $error("post count above limit");
  off_until_good_a: assert property (pwr_q == mhp_pkg::ST_OFF |=> ch_on_q == 2'b00)
    else $error("channel on before supply good");
  load_first_a: assert property (s_load |-> s_run_off)
    else $error("load step not followed by run with channels off");
  qual_on_a: assert property ($rose(ch_on_q[0]) |-> $past(onq_s[0]))
    else $error("channel on without qualified input");
  addr_miss_a: assert property (
    (scl_fall && ist_q == mhp_pkg::I_ADDR && icnt_q == 4'h8 && ish_q[7:1] != addr_q
     && !i_start && !i_stop) |=> ist_q == mhp_pkg::I_IDLE && !sda_oe_q)
    else $error("foreign address acknowledged");
  single_byte_a: assert property (
    (ist_q == mhp_pkg::I_WACK && scl_fall && !i_start && !i_stop) |=> ist_q == mhp_pkg::I_IDLE)
    else $error("second data byte accepted");
endmodule
`default_nettype wire

// file: test/mhp_i2c_master.sv
// Two-wire bus master model that talks to the target port
`timescale 1ns/1ps
`default_nettype none
module mhp_i2c_master (
  // Clock and sensed data line
  input  wire logic clk_i,
  input  wire logic sda_i,
  // Clock line and data pull, pull high holds SDA low
  output logic      scl_o,
  output logic      pull_o
);
  // Idle bus with both lines released
  initial begin
    scl_o = 1'b1;
    pull_o = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Start or repeated start: SDA falls while SCL is high
  task automatic start();
    pull_o <= 1'b0;
    wt(10);
    scl_o <= 1'b1;
    wt(10);
    pull_o <= 1'b1;
    wt(10);
    scl_o <= 1'b0;
    wt(10);
  endtask
  task automatic stop();
    pull_o <= 1'b1;
    wt(10);
    scl_o <= 1'b1;
    wt(10);
    pull_o <= 1'b0;
    wt(10);
  endtask
  // single byte slot
  // Eight bits MSB first then the acknowledge slot; SDA only moves in SCL low
  task automatic xbyte(input logic [8:0] d, output logic [8:0] q);
    for (int i = 8; i >= 0; i--) begin
      pull_o <= ~d[i];
      wt(10);
      scl_o <= 1'b1;
      wt(10);
      q[i] = sda_i;
      scl_o <= 1'b0;
      wt(2);
    end
  endtask
endmodule
`default_nettype wire

// file: test/mhp_top_tb.sv
// Self-checking bench for the supply monitor host port
`timescale 1ns/1ps
`default_nettype none
module mhp_top_tb;
  logic        clk_i, rst_i, cyc, we, ack, sg, vld, scl, pull, sda_oe, irq;
  logic [11:0] adr;
  logic [31:0] wdat, rdat;
  logic [1:0]  asel, sd, ch_on, ls, hs, oq;
  logic [9:0]  adat;
  logic [3:0]  led_oe, lin, lpu, e;
  logic [7:0]  st, r, a;
  logic [8:0]  q;
  logic [2:0]  k;
  logic [9:0]  mdl [50];
  logic [7:0]  tbl [9] = '{8'h60, 8'h62, 8'h64, 8'h68, 8'h6a, 8'h6c, 8'h70, 8'h72, 8'h74};
  int          bad_count, num_checks, wp;
  // Open-drain data line with pull-up
  wire         sda = ~(pull | sda_oe);
  mhp_top #(.FLASH_HALF_CYC(8)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe), .supply_good_i(sg),
    .on_qual_i(oq), .addr_strap_low_i(ls), .addr_strap_high_i(hs),
    .strap_range_i(st[1:0]), .strap_prot_i(st[2]), .strap_pol_i(st[3]),
    .strap_hwen_i(st[4]), .strap_retry_i(st[5]), .adc_valid_i(vld), .adc_sel_i(asel),
    .adc_data_i(adat), .shutdown_i(sd), .ch_on_o(ch_on), .led_o(), .led_oe_o(led_oe),
    .led_pu_o(lpu), .led_in_i(lin), .irq_o(irq));
  mhp_i2c_master m (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));
  // Free-running 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic chk(input string n, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // Classic cycle held until ack is sampled, with an idle cycle after
  task automatic wb(input logic w, input logic [7:0] i, d);
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= {2'h0, i, 2'h0};
    wdat <= {24'h0, d};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    r = rdat[7:0];
    cyc <= 1'b0;
  endtask
  task automatic rd(input string n, input logic [7:0] i, e);
    wb(1'b0, i, 8'h0);
    chk(n, {8'h0, e}, {8'h0, r});
  endtask
  function automatic logic [9:0] exp_smp(input logic b10, input logic [9:0] d);
    return b10 ? d : {2'h0, d[9:2]};
  endfunction
  // Random samples on all buffers; model tracks buffer 0 only while it records
  task automatic feed(input int n, input logic b10, input logic on);
    logic [9:0] d;
    for (int h = 0; h < n;) begin
      d = (h == 0) ? 10'h3ff : 10'($urandom);
      smp(2'($urandom), d);
      if (asel == 2'h0 && on) begin
        mdl[wp] = exp_smp(b10, d);
        wp = (wp + 1) % 50;
      end
      if (asel == 2'h0) h++;
    end
  endtask
  task automatic smp(input logic [1:0] s, input logic [9:0] d);
    @(posedge clk_i);
    vld <= 1'b1;
    asel <= s;
    adat <= d;
    @(posedge clk_i);
    vld <= 1'b0;
  endtask
  task automatic dump();
    logic [7:0] lo;
    for (int i = 0; i < 50; i++) begin
      wb(1'b1, mhp_pkg::R_BUF_IDX, 8'(i));
      wb(1'b0, mhp_pkg::R_BUF_LO, 8'h0);
      lo = r;
      wb(1'b0, mhp_pkg::R_BUF_HI, 8'h0);
      chk("entry", {6'h0, mdl[i]}, {6'h0, r[1:0], lo});
    end
    rd("wptr", mhp_pkg::R_BUF_WPTR, 8'(wp));
  endtask
  task automatic iw(input logic [7:0] ad, c, d);
    m.start();
    m.xbyte({ad, 1'b1}, q);
    k[2] = q[0];
    m.xbyte({c, 1'b1}, q);
    k[1] = q[0];
    m.xbyte({d, 1'b1}, q);
    k[0] = q[0];
    m.stop();
  endtask
  task automatic ir(input logic [7:0] c);
    m.start();
    m.xbyte({a, 1'b1}, q);
    m.xbyte({c, 1'b1}, q);
    m.start();
    m.xbyte({a | 8'h01, 1'b1}, q);
    m.xbyte(9'h1ff, q);
    m.stop();
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the expected run length
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    print_verdict();
  end
  // Main sequence: straps drawn at random, then power-up, ports and buffers
  initial begin
    void'($urandom(74337));
    ls = 2'($urandom % 3);
    hs = 2'($urandom % 3);
    st = 8'($urandom);
    lin = 4'($urandom);
    a = tbl[hs * 3 + ls];
    {rst_i, cyc, we, adr, wdat, sg, vld, asel, adat, sd, wp} = '0;
    rst_i = 1'b1;
    oq = 2'b01;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (20) @(posedge clk_i);
    chk("ch_on", 16'h0, {14'h0, ch_on});
    rd("buf_ctrl", mhp_pkg::R_BUF_CTRL, 8'h01);
    rd("unmapped", 8'h3f, 8'h00);
    sg <= 1'b1;
    repeat (12) @(posedge clk_i);
    chk("ch_on", {15'h0, st[4]}, {14'h0, ch_on});
    rd("ch_ctrl", mhp_pkg::R_CH_CTRL, {6'h0, {2{st[4]}}});
    rd("straps", mhp_pkg::R_STRAPS, {2'h0, st[5:0]});
    wb(1'b1, mhp_pkg::R_CH_CTRL, 8'h03);
    rd("led_in", mhp_pkg::R_LED_IN, {4'h0, lin});
    wb(1'b1, mhp_pkg::R_POST_CNT, 8'h3c);
    rd("post", mhp_pkg::R_POST_CNT, 8'h32);
    iw(a ^ 8'h80, mhp_pkg::R_LED_SET, 8'h0a);
    chk("nack", 16'h1, {15'h0, k[2]});
    iw(a, mhp_pkg::R_LED_SET, 8'h05);
    chk("acks", 16'h0, {13'h0, k});
    chk("led_oe", 16'h5, {12'h0, led_oe});
    ir(mhp_pkg::R_LED_SET);
    chk("i2c read", 16'h5, {8'h0, q[8:1]});
    wb(1'b1, mhp_pkg::R_LED_FLSH, 8'h05);
    wb(1'b1, mhp_pkg::R_LED_PHS, 8'h01);
    wb(1'b1, mhp_pkg::R_LED_PULL, 8'h0a);
    e = led_oe;
    repeat (8) @(posedge clk_i);
    chk("flash", 16'h5, {12'h0, e ^ led_oe});
    chk("phase", 16'h1, {15'h0, led_oe[0] ^ led_oe[2]});
    chk("pull", 16'ha, {12'h0, lpu});
    wb(1'b1, mhp_pkg::R_BUF_SEL, 8'h00);
    wb(1'b1, mhp_pkg::R_BUF_CTRL, 8'h03);
    feed(60, 1'b1, 1'b1);
    dump();
    wb(1'b1, mhp_pkg::R_BUF_CTRL, 8'h02);
    feed(5, 1'b1, 1'b0);
    rd("wptr stop", mhp_pkg::R_BUF_WPTR, 8'(wp));
    wb(1'b1, mhp_pkg::R_BUF_CTRL, 8'h01);
    wb(1'b1, mhp_pkg::R_BUF_CTRL + 8'h01, 8'h00);
    wb(1'b1, mhp_pkg::R_POST_CNT, 8'h03);
    @(posedge clk_i);
    sd <= 2'b01;
    @(posedge clk_i);
    sd <= 2'b00;
    feed(3, 1'b0, 1'b1);
    feed(2, 1'b0, 1'b0);
    dump();
    rd("buf_stat", mhp_pkg::R_BUF_STAT, 8'h11);
    rd("irq_stat", mhp_pkg::R_IRQ_STAT, 8'h11);
    chk("irq masked", 16'h0, {15'h0, irq});
    wb(1'b1, mhp_pkg::R_IRQ_EN, 8'h01);
    repeat (2) @(posedge clk_i);
    chk("irq", 16'h1, {15'h0, irq});
    wb(1'b1, mhp_pkg::R_IRQ_CLR, 8'h01);
    repeat (2) @(posedge clk_i);
    chk("irq cleared", 16'h0, {15'h0, irq});
    rd("irq_stat", mhp_pkg::R_IRQ_STAT, 8'h10);
    oq <= 2'b00;
    repeat (6) @(posedge clk_i);
    chk("ch_off", 16'h0, {14'h0, ch_on});
    print_verdict();
  end
endmodule
`default_nettype wire
